//--- sai_defs.svh
// constants for the shelf alarm indicator block
`ifndef SAI_DEFS_SVH
`define SAI_DEFS_SVH

`define SAI_CLK_HZ 50000000
`define SAI_BLINK_HALF_MS 250
`define SAI_BLINK_HALF_CYC ((`SAI_CLK_HZ / 1000) * `SAI_BLINK_HALF_MS)
`define SAI_DEBOUNCE_MS 20
`define SAI_DEBOUNCE_CYC ((`SAI_CLK_HZ / 1000) * `SAI_DEBOUNCE_MS)
`define SAI_SWITCH_MS 50
`define SAI_SWITCH_CYC ((`SAI_CLK_HZ / 1000) * `SAI_SWITCH_MS)

`define SAI_ADDR_W 8
`define SAI_OFS_STATUS 8'h00
`define SAI_OFS_MASK 8'h04
`define SAI_OFS_CTRL 8'h08
`define SAI_OFS_LAMPS 8'h0c

`define SAI_EV_W 5
`define SAI_EV_SUPPLY 0
`define SAI_EV_NEW_ALARM 1
`define SAI_EV_CUT_PRESS 2
`define SAI_EV_CUT_CANCEL 3
`define SAI_EV_SWITCH 4

`define SAI_CTRL_CUT_EN 0
`define SAI_CTRL_RST 1'b1
`define SAI_MASK_RST 5'h0_0

`endif

//--- sai_indicator_ctrl.sv
// shelf alarm and status indicator control with register port
`timescale 1ns/100ps
`include "sai_defs.svh"

module sai_indicator_ctrl #(
  parameter int unsigned BLINK_HALF_CYC = `SAI_BLINK_HALF_CYC,
  parameter int unsigned DEBOUNCE_CYC = `SAI_DEBOUNCE_CYC
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic [`SAI_ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  output logic irq_out,
  input wire logic booting_in,
  input wire logic db_write_in,
  input wire logic prefer_active_in,
  input wire logic mate_fail_in,
  input wire logic timing_locked_in,
  input wire sai_pkg::sai_alarm_s alarm_in,
  input wire sai_pkg::sai_supply_s supply_a_in,
  input wire sai_pkg::sai_supply_s supply_b_in,
  input wire logic cutoff_button_in,
  output logic fault_lamp_out,
  output sai_pkg::sai_color_e redundancy_role_lamp_out,
  output logic severe_alarm_lamp_out,
  output logic second_tier_alarm_lamp_out,
  output logic minor_alarm_lamp_out,
  output logic far_node_alarm_lamp_out,
  output logic timing_lock_lamp_out,
  output logic audible_cutoff_lamp_out,
  output sai_pkg::sai_color_e supply_a_lamp_out,
  output sai_pkg::sai_color_e supply_b_lamp_out,
  output logic audible_closure_out,
  output logic supply_alarm_out,
  output logic role_active_out
);

  localparam int SYNC_W = 18;

  // colour of a supply lamp from its comparators
  function automatic sai_pkg::sai_color_e supply_color(
    input sai_pkg::sai_supply_s cmp
  );
    sai_pkg::sai_color_e c;
    if (cmp.above_extreme_high || cmp.below_extreme_low) begin
      c = sai_pkg::SAI_RED;
    end else if (cmp.above_high || cmp.below_low) begin
      c = sai_pkg::SAI_AMBER;
    end else begin
      c = sai_pkg::SAI_GREEN;
    end
    return c;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_ff1;
  logic [SYNC_W-1:0] sync_ff2;

  assign sync_raw = {booting_in, db_write_in, prefer_active_in,
                     mate_fail_in, timing_locked_in, alarm_in,
                     supply_a_in, supply_b_in, cutoff_button_in};

  // two flops per pin, first stage read only by second
  // no reset on purpose: pins keep flowing through both
  // stages while reset is held, so the role strap is
  // already settled at the first edge after release
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
      always_ff @(posedge clock_in) begin
        sync_ff1[gi] <= sync_raw[gi];
        sync_ff2[gi] <= sync_ff1[gi];
      end
    end
  endgenerate

  wire booting = sync_ff2[17];
  wire db_write = sync_ff2[16];
  wire prefer_active = sync_ff2[15];
  wire mate_fail = sync_ff2[14];
  wire timing_locked = sync_ff2[13];
  wire sai_pkg::sai_alarm_s alarm_now = sync_ff2[12:9];
  wire sai_pkg::sai_supply_s supply_a = sync_ff2[8:5];
  wire sai_pkg::sai_supply_s supply_b = sync_ff2[4:1];
  wire button = sync_ff2[0];

  //////////////////////////////////////////////////////////////////////
  // blink phase divider

  logic [31:0] blink_cnt;
  logic blink_on;
  wire blink_wrap = (blink_cnt == BLINK_HALF_CYC - 1);

  // toggles blink_on every half period
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      blink_cnt <= 32'h0000_0000;
      blink_on <= 1'b0;
    end else if (blink_wrap) begin
      blink_cnt <= 32'h0000_0000;
      blink_on <= ~blink_on;
    end else begin
      blink_cnt <= blink_cnt + 32'h0000_0001;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // cutoff button debounce

  logic [31:0] deb_cnt;
  logic btn_stable;
  logic btn_stable_d;
  wire btn_differs = (button != btn_stable);
  wire deb_done = (deb_cnt == DEBOUNCE_CYC - 1);
  wire cut_press = btn_stable & ~btn_stable_d;

  // new level accepted only after holding steady
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      deb_cnt <= 32'h0000_0000;
      btn_stable <= 1'b0;
      btn_stable_d <= 1'b0;
    end else begin
      btn_stable_d <= btn_stable;
      if (!btn_differs) begin
        deb_cnt <= 32'h0000_0000;
      end else if (deb_done) begin
        deb_cnt <= 32'h0000_0000;
        btn_stable <= button;
      end else begin
        deb_cnt <= deb_cnt + 32'h0000_0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register port

  // sticky event bits, cleared by a read of status
  logic [`SAI_EV_W-1:0] status;
  logic [`SAI_EV_W-1:0] mask;
  logic cut_enable;
  wire rd_status = reg_rd_in && (reg_addr_in == `SAI_OFS_STATUS);
  wire wr_mask = reg_wr_in && (reg_addr_in == `SAI_OFS_MASK);
  wire wr_ctrl = reg_wr_in && (reg_addr_in == `SAI_OFS_CTRL);

  //////////////////////////////////////////////////////////////////////
  // redundancy role

  sai_pkg::sai_role_e role;
  sai_pkg::sai_role_e next_role;
  wire role_active = (role == sai_pkg::SAI_ROLE_ACTIVE);
  wire ev_switch = (role == sai_pkg::SAI_ROLE_STANDBY) && mate_fail;

  // strap taken after reset; standby takes over at once on mate failure
  always_comb begin
    next_role = role;
    case (role)
      sai_pkg::SAI_ROLE_INIT: begin
        next_role = prefer_active ? sai_pkg::SAI_ROLE_ACTIVE
                                  : sai_pkg::SAI_ROLE_STANDBY;
      end
      sai_pkg::SAI_ROLE_STANDBY: begin
        if (mate_fail) begin
          next_role = sai_pkg::SAI_ROLE_ACTIVE;
        end
      end
      default: begin
        next_role = role;
      end
    endcase
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      role <= sai_pkg::SAI_ROLE_INIT;
    end else begin
      role <= next_role;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // alarm cutoff

  sai_pkg::sai_alarm_s alarm_prev;
  logic [3:0] cut_snap;
  logic cut_active;
  wire any_alarm = |alarm_now;
  wire new_alarm = |(alarm_now & ~alarm_prev);
  wire orig_cleared = ~|(alarm_now & cut_snap);
  wire cut_start = cut_press && cut_enable && any_alarm && !cut_active;
  wire cut_cancel = cut_active && (new_alarm || orig_cleared);

  // cutoff holds until a new alarm or the original one clears
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      alarm_prev <= 4'h0;
      cut_snap <= 4'h0;
      cut_active <= 1'b0;
    end else begin
      alarm_prev <= alarm_now;
      if (cut_cancel) begin
        cut_active <= 1'b0;
        cut_snap <= 4'h0;
      end else if (cut_start) begin
        cut_active <= 1'b1;
        cut_snap <= alarm_now;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // lamp next values

  wire card_busy = booting || db_write;
  sai_pkg::sai_color_e next_role_lamp;
  sai_pkg::sai_color_e next_sup_a;
  sai_pkg::sai_color_e next_sup_b;
  wire next_fault = card_busy & blink_on;
  wire next_supply_alarm = (next_sup_a != sai_pkg::SAI_GREEN) ||
                           (next_sup_b != sai_pkg::SAI_GREEN);

  assign next_sup_a = supply_color(supply_a);
  assign next_sup_b = supply_color(supply_b);

  // role colour, dark on the off phase of a database write
  always_comb begin
    if (role == sai_pkg::SAI_ROLE_INIT) begin
      next_role_lamp = sai_pkg::SAI_OFF;
    end else if (db_write && !blink_on) begin
      next_role_lamp = sai_pkg::SAI_OFF;
    end else if (role_active) begin
      next_role_lamp = sai_pkg::SAI_GREEN;
    end else begin
      next_role_lamp = sai_pkg::SAI_AMBER;
    end
  end

  // lamp flops, fault lamp lit through reset
  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      fault_lamp_out <= 1'b1;
      redundancy_role_lamp_out <= sai_pkg::SAI_OFF;
      severe_alarm_lamp_out <= 1'b0;
      second_tier_alarm_lamp_out <= 1'b0;
      minor_alarm_lamp_out <= 1'b0;
      far_node_alarm_lamp_out <= 1'b0;
      timing_lock_lamp_out <= 1'b0;
      audible_cutoff_lamp_out <= 1'b0;
      supply_a_lamp_out <= sai_pkg::SAI_OFF;
      supply_b_lamp_out <= sai_pkg::SAI_OFF;
      audible_closure_out <= 1'b0;
      supply_alarm_out <= 1'b0;
      role_active_out <= 1'b0;
    end else begin
      fault_lamp_out <= next_fault;
      redundancy_role_lamp_out <= next_role_lamp;
      severe_alarm_lamp_out <= alarm_now.critical;
      second_tier_alarm_lamp_out <= alarm_now.major;
      minor_alarm_lamp_out <= alarm_now.minor;
      far_node_alarm_lamp_out <= alarm_now.remote;
      timing_lock_lamp_out <= timing_locked;
      audible_cutoff_lamp_out <= cut_active;
      supply_a_lamp_out <= next_sup_a;
      supply_b_lamp_out <= next_sup_b;
      audible_closure_out <= any_alarm && !cut_active;
      supply_alarm_out <= next_supply_alarm;
      role_active_out <= role_active;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // events and interrupt

  logic supply_alarm_d;
  logic [`SAI_EV_W-1:0] events;
  logic [`SAI_EV_W-1:0] next_status;

  always_comb begin
    events = '0;
    events[`SAI_EV_SUPPLY] = next_supply_alarm && !supply_alarm_d;
    events[`SAI_EV_NEW_ALARM] = new_alarm;
    events[`SAI_EV_CUT_PRESS] = cut_press;
    events[`SAI_EV_CUT_CANCEL] = cut_cancel;
    events[`SAI_EV_SWITCH] = ev_switch;
  end

  // read clears, an event in the same cycle survives
  assign next_status = (rd_status ? '0 : status) | events;
  assign irq_out = |(status & mask);

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      supply_alarm_d <= 1'b0;
      status <= '0;
    end else begin
      supply_alarm_d <= next_supply_alarm;
      status <= next_status;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // register writes and read data

  wire [31:0] lamps_word = {16'h0000, 3'h0, cut_active,
                            2'(role), 2'(supply_b_lamp_out),
                            2'(supply_a_lamp_out),
                            2'(redundancy_role_lamp_out),
                            fault_lamp_out, timing_lock_lamp_out,
                            audible_closure_out, supply_alarm_out};
  logic [31:0] rd_word;

  // address decode for reads, unmapped reads as zero
  always_comb begin
    if (reg_addr_in == `SAI_OFS_STATUS) begin
      rd_word = {27'h0, status};
    end else if (reg_addr_in == `SAI_OFS_MASK) begin
      rd_word = {27'h0, mask};
    end else if (reg_addr_in == `SAI_OFS_CTRL) begin
      rd_word = {31'h0, cut_enable};
    end else if (reg_addr_in == `SAI_OFS_LAMPS) begin
      rd_word = lamps_word;
    end else begin
      rd_word = 32'h0000_0000;
    end
  end

  always_ff @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mask <= `SAI_MASK_RST;
      cut_enable <= `SAI_CTRL_RST;
      reg_rdata_out <= 32'h0000_0000;
    end else begin
      if (wr_mask) begin
        mask <= reg_wdata_in[`SAI_EV_W-1:0];
      end
      if (wr_ctrl) begin
        cut_enable <= reg_wdata_in[`SAI_CTRL_CUT_EN];
      end
      reg_rdata_out <= reg_rd_in ? rd_word : 32'h0000_0000;
    end
  end

endmodule

//--- sai_indicator_monitor.sv
// assertion checker for the shelf alarm indicator block
`timescale 1ns/100ps
module sai_indicator_monitor #(
  parameter int unsigned BLINK_HALF_CYC = 4,
  parameter int unsigned DEBOUNCE_CYC = 3
) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic booting_in,
  input wire logic db_write_in,
  input wire logic timing_locked_in,
  input wire sai_pkg::sai_alarm_s alarm_in,
  input wire sai_pkg::sai_supply_s supply_a_in,
  input wire sai_pkg::sai_supply_s supply_b_in,
  input wire logic fault_lamp_out,
  input wire sai_pkg::sai_color_e redundancy_role_lamp_out,
  input wire logic severe_alarm_lamp_out,
  input wire logic second_tier_alarm_lamp_out,
  input wire logic minor_alarm_lamp_out,
  input wire logic far_node_alarm_lamp_out,
  input wire logic timing_lock_lamp_out,
  input wire logic audible_cutoff_lamp_out,
  input wire sai_pkg::sai_color_e supply_a_lamp_out,
  input wire sai_pkg::sai_color_e supply_b_lamp_out,
  input wire logic audible_closure_out,
  input wire logic supply_alarm_out,
  input wire logic role_active_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  // colour expected from one set of comparator levels
  function automatic sai_pkg::sai_color_e col(sai_pkg::sai_supply_s s);
    if (s.above_extreme_high || s.below_extreme_low) return sai_pkg::SAI_RED;
    if (s.above_high || s.below_low) return sai_pkg::SAI_AMBER;
    return sai_pkg::SAI_GREEN;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // lamps follow pins three edges later, reset lamp values skipped except the fault lamp, checked lit
  property p_rst_fault;
    disable iff (1'b0) sys_rst_in && $past(sys_rst_in) |-> fault_lamp_out;
  endproperty
  a_rst_fault: assert property (p_rst_fault)
    else $error("fault lamp dark during reset");
  property p_fault_cause;
    !sys_rst_in && !$past(sys_rst_in) && fault_lamp_out
      |-> $past(booting_in, 3) || $past(db_write_in, 3);
  endproperty
  a_fault_cause: assert property (p_fault_cause)
    else $error("fault lamp lit with card idle");
  property p_role_col;
    redundancy_role_lamp_out != sai_pkg::SAI_OFF
      && $past(role_active_out, 2) == role_active_out
      |-> redundancy_role_lamp_out == (role_active_out ? sai_pkg::SAI_GREEN
                                                       : sai_pkg::SAI_AMBER);
  endproperty
  a_role_col: assert property (p_role_col)
    else $error("role lamp colour");
  property p_net;
    !sys_rst_in && !$past(sys_rst_in)
      |-> {severe_alarm_lamp_out, second_tier_alarm_lamp_out,
           minor_alarm_lamp_out, far_node_alarm_lamp_out}
          == $past(alarm_in, 3);
  endproperty
  a_net: assert property (p_net)
    else $error("network alarm lamps");
  property p_sync;
    !sys_rst_in && !$past(sys_rst_in)
      |-> timing_lock_lamp_out == $past(timing_locked_in, 3);
  endproperty
  a_sync: assert property (p_sync)
    else $error("timing lamp");
  property p_sup_a;
    !sys_rst_in && !$past(sys_rst_in)
      |-> supply_a_lamp_out == col($past(supply_a_in, 3));
  endproperty
  a_sup_a: assert property (p_sup_a)
    else $error("supply a lamp");
  property p_sup_b;
    !sys_rst_in && !$past(sys_rst_in)
      |-> supply_b_lamp_out == col($past(supply_b_in, 3));
  endproperty
  a_sup_b: assert property (p_sup_b)
    else $error("supply b lamp");
  property p_sup_alm;
    !sys_rst_in && !$past(sys_rst_in)
      |-> supply_alarm_out
          == (col($past(supply_a_in, 3)) != sai_pkg::SAI_GREEN
              || col($past(supply_b_in, 3)) != sai_pkg::SAI_GREEN);
  endproperty
  a_sup_alm: assert property (p_sup_alm)
    else $error("supply alarm");
  ////////////////////////////////////////////////////////////////////////////
  // audible cutoff sequence
  property p_cut_open;
    $rose(audible_cutoff_lamp_out) |-> ##[0:1] !audible_closure_out;
  endproperty
  a_cut_open: assert property (p_cut_open)
    else $error("closure still closed after cutoff");
  property p_cut_new;
    audible_cutoff_lamp_out && ($past(alarm_in, 2) & ~$past(alarm_in, 3)) != 0
      |-> ##[0:3] !audible_cutoff_lamp_out && audible_closure_out;
  endproperty
  a_cut_new: assert property (p_cut_new)
    else $error("cutoff not cancelled by new alarm");
  property p_cut_clr;
    audible_cutoff_lamp_out && $past(alarm_in, 2) == 4'h0
      |-> ##[0:3] !audible_cutoff_lamp_out && !audible_closure_out;
  endproperty
  a_cut_clr: assert property (p_cut_clr)
    else $error("cutoff not idle after alarm cleared");
endmodule

bind sai_indicator_ctrl sai_indicator_monitor #(
  .BLINK_HALF_CYC(BLINK_HALF_CYC),
  .DEBOUNCE_CYC(DEBOUNCE_CYC)
) mon (.clock_in, .sys_rst_in, .booting_in, .db_write_in, .timing_locked_in,
  .alarm_in, .supply_a_in, .supply_b_in, .fault_lamp_out,
  .redundancy_role_lamp_out, .severe_alarm_lamp_out,
  .second_tier_alarm_lamp_out, .minor_alarm_lamp_out,
  .far_node_alarm_lamp_out, .timing_lock_lamp_out, .audible_cutoff_lamp_out,
  .supply_a_lamp_out, .supply_b_lamp_out, .audible_closure_out,
  .supply_alarm_out, .role_active_out);

//--- sai_panel_model.sv
// front panel model: a cutoff button that bounces
`timescale 1ns/100ps
module sai_panel_model (
  input wire logic clock_in,
  output logic cutoff_button_out
);
  initial cutoff_button_out = 1'b0;
  // contact chatter shorter than the debounce span, then a steady hold
  task automatic press(input int hold);
    for (int i = 0; i < 5; i++) begin
      @(posedge clock_in);
      cutoff_button_out <= (i % 2 == 0);
    end
    repeat (hold) @(posedge clock_in);
    for (int i = 0; i < 3; i++) begin
      @(posedge clock_in);
      cutoff_button_out <= (i == 1);
    end
  endtask
endmodule

//--- sai_pkg.sv
// types of the shelf alarm indicator block
package sai_pkg;

  typedef enum logic [1:0] {
    SAI_OFF,
    SAI_GREEN,
    SAI_AMBER,
    SAI_RED
  } sai_color_e;

  typedef enum logic [1:0] {
    SAI_ROLE_INIT,
    SAI_ROLE_STANDBY,
    SAI_ROLE_ACTIVE
  } sai_role_e;

  // network alarm presence by severity
  typedef struct packed {
    logic critical;
    logic major;
    logic minor;
    logic remote;
  } sai_alarm_s;

  // supply comparator outputs, one per threshold
  typedef struct packed {
    logic above_extreme_high;
    logic above_high;
    logic below_low;
    logic below_extreme_low;
  } sai_supply_s;

endpackage

//--- test_shelf_alarm_indicator_control.sv
// self-checking testbench of the shelf alarm indicator block
`timescale 1ns/100ps
`include "sai_defs.svh"
module test_shelf_alarm_indicator_control;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0000_0000;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, booting_in = 1'b0;
  logic db_write_in = 1'b0, prefer_active_in = 1'b1, mate_fail_in = 1'b0;
  logic timing_locked_in = 1'b0, cutoff_button_in;
  sai_pkg::sai_alarm_s alarm_in = '0;
  sai_pkg::sai_supply_s supply_a_in = '0, supply_b_in = '0;
  logic [31:0] reg_rdata_out;
  logic irq_out, fault_lamp_out, severe_alarm_lamp_out, minor_alarm_lamp_out;
  logic second_tier_alarm_lamp_out, far_node_alarm_lamp_out, role_active_out;
  logic timing_lock_lamp_out, audible_cutoff_lamp_out, audible_closure_out;
  logic supply_alarm_out;
  sai_pkg::sai_color_e redundancy_role_lamp_out, supply_a_lamp_out;
  sai_pkg::sai_color_e supply_b_lamp_out;
  int mismatches = 0, cmp_count = 0;

  sai_indicator_ctrl #(.BLINK_HALF_CYC(4), .DEBOUNCE_CYC(3)) dut (.clock_in,
    .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .irq_out, .booting_in, .db_write_in, .prefer_active_in,
    .mate_fail_in, .timing_locked_in, .alarm_in, .supply_a_in, .supply_b_in,
    .cutoff_button_in, .fault_lamp_out, .redundancy_role_lamp_out,
    .severe_alarm_lamp_out, .second_tier_alarm_lamp_out, .minor_alarm_lamp_out,
    .far_node_alarm_lamp_out, .timing_lock_lamp_out, .audible_cutoff_lamp_out,
    .supply_a_lamp_out, .supply_b_lamp_out, .audible_closure_out,
    .supply_alarm_out, .role_active_out);
  sai_panel_model panel (.clock_in(clock_in),
    .cutoff_button_out(cutoff_button_in));

  always #10 clock_in = ~clock_in;
  ////////////////////////////////////////////////////////////////////////////
  // compare, verdict, bus cycles
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  // model colour: 1 green, 2 amber, 3 red
  function automatic int exp_col(int s);
    if (s[3] || s[0]) return 3;
    if (s[2] || s[1]) return 2;
    return 1;
  endfunction
  // cutoff press then a new lamp state settles
  task automatic cut(input logic [3:0] alm, input int lamp, closure);
    panel.press(8);
    tick(4);
    chk("cut_lamp", audible_cutoff_lamp_out, lamp);
    chk("closure", audible_closure_out, closure);
    @(posedge clock_in);
    alarm_in <= alm;
    tick(6);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // watchdog: tests need about 310 cycles, allow 20,000
  initial begin
    #400000;
    mismatches++;
    give_verdict();
  end

  initial begin
    logic [31:0] d;
    int pats[$];
    int on, off, ron, roff;
    void'($urandom(32'hf040));
    tick(4);
    chk("fault_rst", fault_lamp_out, 1);
    @(posedge clock_in);
    sys_rst_in <= 1'b0;
    tick(3);
    rd(`SAI_OFS_MASK, d);
    chk("mask_rst", d, 32'h0000_0000);
    rd(`SAI_OFS_CTRL, d);
    chk("ctrl_rst", d, 32'h0000_0001);
    rd(8'h10, d);
    chk("unmapped", d, 32'h0000_0000);
    chk("role_act", redundancy_role_lamp_out, sai_pkg::SAI_GREEN);
    repeat (24) pats.push_back($urandom);
    pats.push_back(32'h0000_1fff);
    pats.push_back(32'h0000_0000);
    foreach (pats[i]) begin
      @(posedge clock_in);
      supply_a_in <= pats[i][3:0];
      supply_b_in <= pats[i][7:4];
      alarm_in <= pats[i][11:8];
      timing_locked_in <= pats[i][12];
      tick(4);
      chk("sup_a", supply_a_lamp_out,
          exp_col(pats[i][3:0]));
      chk("sup_b", supply_b_lamp_out, exp_col(pats[i][7:4]));
      chk("sup_alm", supply_alarm_out, exp_col(pats[i][3:0]) != 1 ||
          exp_col(pats[i][7:4]) != 1);
      chk("net", {severe_alarm_lamp_out, second_tier_alarm_lamp_out,
          minor_alarm_lamp_out, far_node_alarm_lamp_out},
          pats[i][11:8]);
      chk("sync", timing_lock_lamp_out, pats[i][12]);
    end
    chk("irq_masked", irq_out, 0);
    // booting, then database write: fault flashes, role lamp blinks on write
    for (int k = 0; k < 2; k++) begin
      @(posedge clock_in);
      booting_in <= (k == 0);
      db_write_in <= (k == 1);
      tick(4);
      on = 0; off = 0; ron = 0; roff = 0;
      repeat (16) begin
        tick(1);
        if (fault_lamp_out === 1'b1) on++;
        if (fault_lamp_out === 1'b0) off++;
        if (redundancy_role_lamp_out === sai_pkg::SAI_OFF) roff++;
        if (redundancy_role_lamp_out === sai_pkg::SAI_GREEN) ron++;
      end
      chk("fault_flash", on > 0 && off > 0, 1);
      chk("role_blink", ron > 0 && roff > 0, k == 1);
    end
    @(posedge clock_in);
    db_write_in <= 1'b0;
    tick(4);
    chk("fault_idle", fault_lamp_out, 0);
    rd(`SAI_OFS_STATUS, d);
    wr(`SAI_OFS_MASK, 32'h0000_001f);
    @(posedge clock_in);
    alarm_in <= 4'b1000;
    tick(4);
    chk("sounding", audible_closure_out, 1);
    chk("irq_on", irq_out, 1);
    cut(4'b1100, 1, 0);
    chk("new_cut_lamp", audible_cutoff_lamp_out, 0);
    chk("new_closure", audible_closure_out, 1);
    rd(`SAI_OFS_STATUS, d);
    chk("status", d, 32'h0000_000e);
    chk("irq_clear", irq_out, 0);
    cut(4'b0000, 1, 0);
    chk("idle_lamp", audible_cutoff_lamp_out, 0);
    chk("idle_closure", audible_closure_out, 0);
    wr(`SAI_OFS_CTRL, 32'h0000_0000);
    @(posedge clock_in);
    alarm_in <= 4'b0010;
    tick(4);
    cut(4'b0000, 0, 1);
    // restart as standby, then the mate fails
    @(posedge clock_in);
    sys_rst_in <= 1'b1;
    prefer_active_in <= 1'b0;
    tick(2);
    chk("fault_mid_rst", fault_lamp_out, 1);
    @(posedge clock_in);
    sys_rst_in <= 1'b0;
    tick(4);
    chk("role_stby", redundancy_role_lamp_out, sai_pkg::SAI_AMBER);
    @(posedge clock_in);
    mate_fail_in <= 1'b1;
    for (int n = 0; n < 50 && role_active_out !== 1'b1; n++) tick(1);
    tick(2);
    chk("takeover", role_active_out, 1);
    chk("role_new", redundancy_role_lamp_out, sai_pkg::SAI_GREEN);
    rd(`SAI_OFS_STATUS, d);
    chk("switch_ev", d[4], 1);
    give_verdict();
  end
endmodule
